// File: pkg/amb_cfg.svh
// timing counts and field positions for the converter bus interface
`ifndef AMB_CFG_SVH
`define AMB_CFG_SVH
`define AMB_CLK_PERIOD_PS   8000
`define AMB_CONV_TIME_NS    40000
`define AMB_CONV_CYCLES     (`AMB_CONV_TIME_NS * 1000 / `AMB_CLK_PERIOD_PS)
`define AMB_MUX_BITS        5
`define AMB_DATA_BITS       8
`define AMB_SEL_LO          0
`define AMB_SEL_HI          1
`define AMB_MODE_A          2
`define AMB_MODE_B          3
`define AMB_RESET_CFG       4'h0
`define AMB_RESET_RESULT    8'h00
`endif

// File: pkg/amb_pkg.sv
// types for the converter bus interface
package amb_pkg;
  typedef enum logic [1:0] {
    AMB_IDLE = 2'b00,
    AMB_CONV = 2'b01,
    AMB_DONE = 2'b11
  } amb_state_t;

  typedef enum logic [1:0] {
    AMB_DIFF   = 2'b00,
    AMB_SINGLE = 2'b01,
    AMB_PSEUDO = 2'b10,
    AMB_RSVD   = 2'b11
  } amb_mode_t;

  typedef struct packed {
    amb_mode_t  mode;
    logic [2:0] pos_sel;   // 0..3 channel one..four
    logic [2:0] neg_sel;   // 0..3 channel, 4 analog ground
  } amb_route_t;
endpackage : amb_pkg

// File: rtl/amb_sar.sv
// successive-approximation engine, one bit per step
`timescale 1ns/1ps
`include "amb_cfg.svh"
module amb_sar
  import amb_pkg::*;
#(
  parameter int unsigned W     = 8,
  parameter int unsigned STEPS = 5000
)(
  input  wire logic         clk,      // clock
  input  wire logic         rst,      // async reset
  input  wire logic         ce,       // clock enable
  input  wire logic         start,    // begin conversion
  input  wire logic [W-1:0] vpos,     // positive input sample
  input  wire logic [W-1:0] vneg,     // negative input sample
  output logic              done,     // one-cycle completion pulse
  output logic [W-1:0]      code      // result
);
  localparam int unsigned PER = (STEPS / W) < 1 ? 1 : STEPS / W;
  logic [W-1:0]  trial_r;
  logic [W-1:0]  bitp_r;
  logic [31:0]   tick_r;
  logic          busy_r;
  logic [W-1:0]  diff;

  // below-zero difference converts to the all-zero code
  assign diff = (vpos > vneg) ? vpos - vneg : '0;

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      trial_r <= '0;
      bitp_r  <= '0;
      tick_r  <= '0;
      busy_r  <= 1'b0;
      done    <= 1'b0;
      code    <= '0;
    end
    else if (ce)
    begin
      done <= 1'b0;
      if (start)
      begin
        busy_r  <= 1'b1;
        bitp_r  <= {1'b1, {(W-1){1'b0}}};
        trial_r <= '0;
        tick_r  <= '0;
      end
      else if (busy_r)
      begin
        if (tick_r == PER - 1)
        begin
          tick_r <= '0;
          // keep the trial bit when the trial does not exceed the input
          if ((trial_r | bitp_r) <= diff)
            trial_r <= trial_r | bitp_r;
          bitp_r <= bitp_r >> 1;
          if (bitp_r[0])
          begin
            busy_r <= 1'b0;
            done   <= 1'b1;
            code   <= ((trial_r | bitp_r) <= diff) ? (trial_r | bitp_r) : trial_r;
          end
        end
        else
          tick_r <= tick_r + 32'd1;
      end
    end
  end
endmodule : amb_sar

// File: rtl/amb_conv_ctrl.sv
// bus-side control of the multiplexed 8-bit converter
`timescale 1ns/1ps
`include "amb_cfg.svh"
module amb_conv_ctrl
  import amb_pkg::*;
#(
  parameter int unsigned CONV_CYCLES = `AMB_CONV_CYCLES
)(
  input  wire logic       clk,                    // 125 MHz clock
  input  wire logic       rst,                    // async reset, active high
  input  wire logic       ce,                     // clock enable
  input  wire logic       cs_n,                   // chip select pin
  input  wire logic       wr_n,                   // write strobe pin
  input  wire logic       rd_n,                   // read strobe pin
  input  wire logic [7:0] result_bus_lines_in,    // data pins, input side
  output logic      [7:0] result_bus_lines_out,   // data pins, output side
  output logic            result_bus_lines_oe,    // data pins driven
  output logic            conversion_done_n,      // done line, low when result ready
  input  wire logic [7:0] analog_input_channels [4], // sampled channel levels
  input  wire logic [7:0] analog_ground_input,    // ground level sample
  output logic      [3:0] active_config           // latched select bits
);
  // ============================================================
  // pin synchronisers
  logic [1:0] cs_s, wr_s, rd_s;
  logic [7:0] db_s1, db_s2;
  logic       wr_d;
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      cs_s  <= 2'b11;
      wr_s  <= 2'b11;
      rd_s  <= 2'b11;
      db_s1 <= 8'h00;
      db_s2 <= 8'h00;
      wr_d  <= 1'b1;
    end
    else if (ce)
    begin
      cs_s  <= {cs_s[0], cs_n};
      wr_s  <= {wr_s[0], wr_n};
      rd_s  <= {rd_s[0], rd_n};
      db_s1 <= result_bus_lines_in;
      db_s2 <= db_s1;
      wr_d  <= wr_s[1];
    end
  end
  logic cs_q, wr_q, rd_q, wr_fall, wr_rise, read_act;
  assign cs_q     = cs_s[1];
  assign wr_q     = wr_s[1];
  assign rd_q     = rd_s[1];
  assign wr_fall  = !cs_q && wr_d && !wr_q;
  assign wr_rise  = !cs_q && !wr_d && wr_q;
  assign read_act = !cs_q && !rd_q;

  // ============================================================
  // select decode
  function automatic amb_route_t decode(input logic [3:0] sel);
    amb_route_t r;
    r.mode    = AMB_DIFF;
    r.pos_sel = 3'd0;
    r.neg_sel = 3'd4;
    if (!sel[`AMB_MODE_A])
    begin
      r.mode    = AMB_DIFF;
      r.pos_sel = {1'b0, sel[`AMB_SEL_HI], sel[`AMB_SEL_LO]};
      r.neg_sel = {1'b0, sel[`AMB_SEL_HI], !sel[`AMB_SEL_LO]};
    end
    else if (!sel[`AMB_MODE_B])
    begin
      r.mode    = AMB_SINGLE;
      r.pos_sel = {1'b0, sel[`AMB_SEL_HI:`AMB_SEL_LO]};
      r.neg_sel = 3'd4;
    end
    else if (sel[`AMB_SEL_HI:`AMB_SEL_LO] != 2'b11)
    begin
      r.mode    = AMB_PSEUDO;
      r.pos_sel = {1'b0, sel[`AMB_SEL_HI:`AMB_SEL_LO]};
      r.neg_sel = 3'd3;
    end
    else
    begin
      // reserved pattern: fall back to channel one against ground
      r.mode    = AMB_RSVD;
      r.pos_sel = 3'd0;
      r.neg_sel = 3'd4;
    end
    return r;
  endfunction : decode

  function automatic logic [7:0] pick(input logic [2:0] s,
                                      input logic [7:0] ch [4],
                                      input logic [7:0] gnd);
    return (s == 3'd4) ? gnd : ch[s[1:0]];
  endfunction : pick

  // ============================================================
  // write cycle tracking and mux latch
  logic [3:0] cfg_r;
  logic       rd_hi_seen_r;   // read went high during this write pulse
  logic       start_r;
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      cfg_r        <= `AMB_RESET_CFG;
      rd_hi_seen_r <= 1'b0;
      start_r      <= 1'b0;
    end
    else if (ce)
    begin
      start_r <= 1'b0;
      if (wr_fall)
        rd_hi_seen_r <= rd_q;
      else if (!wr_q && rd_q)
        rd_hi_seen_r <= 1'b1;
      if (wr_rise)
      begin
        start_r <= 1'b1;
        // select bits are only sampled with read high
        if (rd_q && rd_hi_seen_r)
          cfg_r <= db_s2[3:0];
        // read held low all along keeps the old configuration
      end
    end
  end

  amb_route_t route;
  logic [7:0] vpos, vneg;
  assign route = decode(cfg_r);
  assign vpos  = pick(route.pos_sel, analog_input_channels, analog_ground_input);
  assign vneg  = pick(route.neg_sel, analog_input_channels, analog_ground_input);

  // ============================================================
  // converter and output latch
  logic       sar_done;
  logic [7:0] sar_code;
  amb_sar #(.W(`AMB_DATA_BITS), .STEPS(CONV_CYCLES)) u_sar (
    .clk   (clk),
    .rst   (rst),
    .ce    (ce),
    .start (start_r),
    .vpos  (vpos),
    .vneg  (vneg),
    .done  (sar_done),
    .code  (sar_code)
  );

  amb_state_t st_r;
  logic [7:0] latch_r;
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      st_r              <= AMB_IDLE;
      latch_r           <= `AMB_RESET_RESULT;
      conversion_done_n <= 1'b1;
    end
    else if (ce)
    begin
      case (st_r)
        AMB_IDLE, AMB_DONE:
        begin
          if (start_r)
            st_r <= AMB_CONV;
        end
        AMB_CONV:
        begin
          if (sar_done)
          begin
            st_r    <= AMB_DONE;
            latch_r <= sar_code;
          end
        end
        default: st_r <= AMB_IDLE;
      endcase
      // completion sets the line low and wins over a coincident clear
      if (st_r == AMB_CONV && sar_done)
        conversion_done_n <= 1'b0;
      else if (wr_fall || read_act)
        conversion_done_n <= 1'b1;
    end
  end

  // ============================================================
  // data pin drive
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      result_bus_lines_out <= 8'h00;
      result_bus_lines_oe  <= 1'b0;
      active_config        <= `AMB_RESET_CFG;
    end
    else if (ce)
    begin
      result_bus_lines_out <= latch_r;
      result_bus_lines_oe  <= read_act;
      active_config        <= cfg_r;
    end
  end

  // ============================================================
  // checks
  sequence s_done_fall;
    ce && st_r == AMB_CONV && sar_done;
  endsequence

  property p_done_low;
    @(posedge clk) disable iff (rst)
    s_done_fall |=> !conversion_done_n;
  endproperty
  a_done_low: assert property (p_done_low) else $error("done line not low");

  property p_wr_clear;
    @(posedge clk) disable iff (rst)
    (ce && wr_fall && !(st_r == AMB_CONV && sar_done)) |=> conversion_done_n;
  endproperty
  a_wr_clear: assert property (p_wr_clear) else $error("write fall left done low");

  property p_rd_clear;
    @(posedge clk) disable iff (rst)
    (ce && read_act && !(st_r == AMB_CONV && sar_done)) |=> conversion_done_n;
  endproperty
  a_rd_clear: assert property (p_rd_clear) else $error("read left done low");

  property p_hold;
    @(posedge clk) disable iff (rst)
    (ce && !conversion_done_n && !wr_fall && !read_act) |=> !conversion_done_n;
  endproperty
  a_hold: assert property (p_hold) else $error("done line rose unread");

  property p_oe;
    @(posedge clk) disable iff (rst)
    ce |=> (result_bus_lines_oe == $past(read_act));
  endproperty
  a_oe: assert property (p_oe) else $error("data drive mismatch");

  property p_keep_cfg;
    @(posedge clk) disable iff (rst)
    (ce && wr_rise && !(rd_q && rd_hi_seen_r)) |=> $stable(cfg_r);
  endproperty
  a_keep_cfg: assert property (p_keep_cfg) else $error("config changed on read-low write");

  property p_latch_cfg;
    @(posedge clk) disable iff (rst)
    (ce && wr_rise && rd_q && rd_hi_seen_r) |=> cfg_r == $past(db_s2[3:0]);
  endproperty
  a_latch_cfg: assert property (p_latch_cfg) else $error("config not latched");

  property p_start;
    @(posedge clk) disable iff (rst)
    (ce && wr_rise) |=> start_r;
  endproperty
  a_start: assert property (p_start) else $error("no start after write rise");

  property p_single;
    @(posedge clk) disable iff (rst)
    (cfg_r[3:2] == 2'b01) |-> (route.neg_sel == 3'd4);
  endproperty
  a_single: assert property (p_single) else $error("single-ended not to ground");
endmodule : amb_conv_ctrl

// File: verif/amb_host_model.sv
// host bus model: strobes, data pins and the wait after done
`timescale 1ns/1ps
module amb_host_model (
  input  wire logic       clk,      // clock
  input  wire logic       done_n,   // done line from device
  input  wire logic [7:0] dev_out,  // device data output
  input  wire logic       dev_oe,   // device drives data
  output logic            cs_n,     // chip select
  output logic            wr_n,     // write strobe
  output logic            rd_n,     // read strobe
  output logic      [7:0] bus       // resolved data pins
);
  logic       drv_r;
  logic [7:0] d_r;
  logic [7:0] last_r;
  int         age_r;
  // a released bus shows the inverse of its last value, never a stale match
  assign bus = drv_r ? d_r : (dev_oe ? dev_out : ~last_r);
  initial
  begin
    cs_n = 1'b1;
    wr_n = 1'b1;
    rd_n = 1'b1;
    drv_r = 1'b0;
    d_r = 8'h00;
    last_r = 8'h00;
    age_r = 0;
  end
  always @(posedge clk)
  begin
    last_r <= bus;
    age_r <= done_n ? 0 : age_r + 1;
  end
  // ==========================================================
  // write pulse; hold_rd keeps the read strobe low throughout
  task do_write(input logic [7:0] d, input logic hold_rd, output logic dn,
                output logic [7:0] rb);
    @(negedge clk);
    cs_n = 1'b0;
    wr_n = 1'b0;
    rd_n = ~hold_rd;
    drv_r = ~hold_rd;
    d_r = d;
    repeat (10) @(negedge clk);
    dn = done_n;
    rb = bus;
    wr_n = 1'b1;
    // select bits held past the synced rise
    repeat (6) @(negedge clk);
    cs_n = 1'b1;
    rd_n = 1'b1;
    drv_r = 1'b0;
  endtask : do_write
  task do_read(output logic [7:0] d, output logic dn, output logic oe);
    while (done_n === 1'b0 && age_r < 75) @(negedge clk);
    @(negedge clk);
    cs_n = 1'b0;
    rd_n = 1'b0;
    repeat (6) @(negedge clk);
    d = bus;
    dn = done_n;
    oe = dev_oe;
    cs_n = 1'b1;
    rd_n = 1'b1;
  endtask : do_read
endmodule : amb_host_model

// File: verif/amb_conv_ctrl_tb.sv
// self-checking bench for the converter bus control
`timescale 1ns/1ps
module amb_conv_ctrl_tb;
  import amb_pkg::*;
  localparam int unsigned CONV = 64;
  logic       clk, rst, ce, cs_n, wr_n, rd_n, oe, done_n, dn, oe_s;
  logic [7:0] bus, dout, gnd, lfsr_r, exp_code, rd_d, rb, prev, v;
  logic [7:0] ch [4];
  logic [3:0] cfg, cur_cfg;
  int         failures, checks_done, cycles;
  amb_conv_ctrl #(.CONV_CYCLES(CONV)) u_amb_conv_ctrl (
    .clk(clk), .rst(rst), .ce(ce), .cs_n(cs_n), .wr_n(wr_n), .rd_n(rd_n),
    .result_bus_lines_in(bus), .result_bus_lines_out(dout),
    .result_bus_lines_oe(oe), .conversion_done_n(done_n),
    .analog_input_channels(ch), .analog_ground_input(gnd), .active_config(cfg));
  amb_host_model u_amb_host_model (
    .clk(clk), .done_n(done_n), .dev_out(dout), .dev_oe(oe),
    .cs_n(cs_n), .wr_n(wr_n), .rd_n(rd_n), .bus(bus));
  // ==========================================================
  // expectations and compares
  function automatic logic [7:0] lfsr_next(input logic [7:0] x);
    return {x[6:0], x[7] ^ x[5] ^ x[4] ^ x[3]};
  endfunction : lfsr_next
  function automatic logic [7:0] exp_of(input logic [3:0] s);
    logic [7:0] p;
    logic [7:0] n;
    if (!s[2])
    begin
      p = ch[{s[1], s[0]}];
      n = ch[{s[1], ~s[0]}];
    end
    else if (!s[3])
    begin
      p = ch[s[1:0]];
      n = gnd;
    end
    else if (s[1:0] != 2'b11)
    begin
      p = ch[s[1:0]];
      n = ch[3];
    end
    else
    begin
      p = ch[0];
      n = gnd;
    end
    return (p > n) ? p - n : 8'h00;
  endfunction : exp_of
  task chk_byte(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      failures++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_byte
  task chk_bit(input logic got, input logic exp);
    chk_byte({7'h00, got}, {7'h00, exp});
  endtask : chk_bit
  task final_report;
    $display("failures=%0d checks_done=%0d", failures, checks_done);
    if (failures == 0 && checks_done > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : final_report
  task rnd(output logic [7:0] r);
    lfsr_r = lfsr_next(lfsr_r);
    r = lfsr_r;
  endtask : rnd
  // ==========================================================
  // one conversion; a skipped read leaves done low for the next write
  task convert(input logic [7:0] d, input logic hold, input logic do_rd);
    int k;
    for (k = 0; k < 4; k++) rnd(ch[k]);
    rnd(gnd);
    gnd = gnd >> 3;
    if (!hold) cur_cfg = d[3:0];
    exp_code = exp_of(cur_cfg);
    u_amb_host_model.do_write(d, hold, dn, rb);
    chk_bit(dn, 1'b1);
    if (hold) chk_byte(rb, prev);
    k = 0;
    while (done_n !== 1'b0 && k < CONV + 40)
    begin
      @(negedge clk);
      k++;
    end
    chk_bit(done_n, 1'b0);
    chk_byte({4'h0, cfg}, {4'h0, cur_cfg});
    repeat (20) @(negedge clk);
    chk_bit(done_n, 1'b0);
    prev = exp_code;
    if (do_rd)
    begin
      u_amb_host_model.do_read(rd_d, dn, oe_s);
      chk_byte(rd_d, exp_code);
      chk_bit(dn, 1'b1);
      chk_bit(oe_s, 1'b1);
      repeat (4) @(negedge clk);
      chk_bit(oe, 1'b0);
    end
  endtask : convert
  // ==========================================================
  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      failures++;
      final_report();
    end
  end
  initial
  begin
    rst = 1'b1;
    ce = 1'b1;
    gnd = 8'h00;
    for (int i = 0; i < 4; i++) ch[i] = 8'h00;
    lfsr_r = 8'h1c;
    prev = 8'h00;
    cur_cfg = 4'h0;
    failures = 0;
    checks_done = 0;
    cycles = 0;
    repeat (3) @(negedge clk);
    rst = 1'b0;
    @(negedge clk);
    chk_bit(done_n, 1'b1);
    chk_bit(oe, 1'b0);
    chk_byte({4'h0, cfg}, 8'h00);
    for (int s = 0; s < 16; s++)
    begin
      rnd(v);
      convert({v[7:4], s[3:0]}, 1'b0, 1'b1);
    end
    rnd(v);
    convert(v, 1'b0, 1'b0);
    // unread result, then a write with the read strobe held low
    rnd(v);
    convert(v, 1'b1, 1'b1);
    // unread result again: the next write has read high, so only its fall clears
    rnd(v);
    convert(v, 1'b0, 1'b0);
    repeat (4)
    begin
      rnd(v);
      convert(v, 1'b0, 1'b1);
    end
    // enable low in mid-conversion: the count must stop, then resume
    rnd(v);
    u_amb_host_model.do_write(v, 1'b0, dn, rb);
    ce = 1'b0;
    repeat (CONV + 40) @(negedge clk);
    chk_bit(done_n, 1'b1);
    ce = 1'b1;
    repeat (CONV + 8) @(negedge clk);
    chk_bit(done_n, 1'b0);
    chk_byte({4'h0, cfg}, {4'h0, v[3:0]});
    final_report();
  end
endmodule : amb_conv_ctrl_tb
